// ===== common/doorbell_pkg.sv
package doorbell_pkg;
  localparam int unsigned clk_freq_hz = 250_000_000;
  localparam int unsigned tick_1ms_ms = 1;
  localparam int unsigned tick_200ms_ms = 200;
  localparam int unsigned tick_500ms_ms = 500;
  localparam int unsigned tick_5s_ms = 5000;
  localparam int unsigned ms_cycles = clk_freq_hz / 1000;
  localparam int unsigned debounce_ms = 20;
  localparam int unsigned power_settle_ms = 1;
  localparam int unsigned reset_hold_ms = 1;
  localparam int unsigned init_wait_ms = 200;
  localparam int unsigned baud_rate = 115_200;
  localparam int unsigned baud_cycles = clk_freq_hz / baud_rate;
  localparam int unsigned msg_len = 4;
  localparam logic [7:0] msg_bytes [msg_len] = '{8'ha5, 8'h5a, 8'hd0, 8'h01};
  localparam int unsigned init_len = 2;
  localparam logic [7:0] init_bytes [init_len] = '{8'hc3, 8'h00};
  localparam int unsigned blink_toggles = tick_5s_ms / tick_500ms_ms;
  localparam logic [9:0] adc_low_threshold = 10'h3b6;
  localparam logic led_off_level = 1'b1;
  localparam logic led_on_level = 1'b0;

  typedef struct packed {
    logic led_n;
    logic radio_power;
    logic radio_reset_n;
  } radio_ctrl_type;

  typedef struct packed {
    logic valid;
    logic [9:0] value;
  } adc_result_type;
endpackage

// ===== core/uart_tx.sv
`timescale 1ns/1ps
module uart_tx #(
  parameter int unsigned baud_div = 2170
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [7:0] data,
  output logic busy,
  output logic tx_line
);
  logic [15:0] baud_reg;
  logic [3:0] bit_reg;
  logic [9:0] shift_reg;

  // frame: start bit, 8 data lsb first, stop bit
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      busy <= 1'b0;
      tx_line <= 1'b1;
      baud_reg <= 16'h0000;
      bit_reg <= 4'h0;
      shift_reg <= 10'h3ff;
    end else if (!busy) begin
      tx_line <= 1'b1;
      if (start) begin
        busy <= 1'b1;
        shift_reg <= {1'b1, data, 1'b0};
        baud_reg <= 16'h0000;
        bit_reg <= 4'h0;
        tx_line <= 1'b0;
      end
    end else if (baud_reg == 16'(baud_div - 1)) begin
      baud_reg <= 16'h0000;
      if (bit_reg == 4'h9) begin
        busy <= 1'b0;
        tx_line <= 1'b1;
      end else begin
        bit_reg <= bit_reg + 4'h1;
        shift_reg <= {1'b1, shift_reg[9:1]};
        tx_line <= shift_reg[1];
      end
    end else begin
      baud_reg <= baud_reg + 16'h0001;
    end
  end
endmodule

// ===== core/doorbell_transmit_sequencer.sv
`timescale 1ns/1ps
module doorbell_transmit_sequencer #(
  parameter int unsigned tick_div = doorbell_pkg::ms_cycles,
  parameter int unsigned debounce_ticks = doorbell_pkg::debounce_ms,
  parameter int unsigned baud_div = doorbell_pkg::baud_cycles
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic key_interrupt_input,
  input wire logic key_input_pin,
  input wire doorbell_pkg::adc_result_type adc_result,
  input wire logic radio_serial_rx_line,
  output logic led_drive_pin,
  output logic radio_power_switch_pin,
  output logic radio_reset_pin,
  output logic radio_serial_tx_line,
  output logic adc_start
);
  import doorbell_pkg::*;

  typedef enum {st_init, st_sleep, st_debounce, st_power, st_reset,
    st_boot, st_send, st_held, st_check, st_blink} state_type;
  state_type state_reg;

  logic [17:0] ms_div_reg;
  logic tick_1ms;
  logic [7:0] cnt200_reg;
  logic [8:0] cnt500_reg;
  logic [12:0] cnt5s_reg;
  logic tick_200ms, tick_500ms, tick_5s;
  logic [15:0] wait_reg;
  logic [2:0] byte_reg;
  logic init_phase_reg;
  logic resend_done_reg;
  logic [4:0] blink_reg;
  logic run;
  logic tx_start, tx_busy, tx_line;
  logic [7:0] tx_data;
  logic low_batt_reg;
  logic rx_sync_reg;

  // ticks only run while awake, so the tick counters sit at zero in sleep
  assign run = (state_reg != st_sleep) && (state_reg != st_init);

  always_ff @(posedge ref_clk) begin
    if (!rst_n || !run) begin
      ms_div_reg <= 18'h00000;
      tick_1ms <= 1'b0;
    end else if (ms_div_reg == 18'(tick_div - 1)) begin
      ms_div_reg <= 18'h00000;
      tick_1ms <= 1'b1;
    end else begin
      ms_div_reg <= ms_div_reg + 18'h00001;
      tick_1ms <= 1'b0;
    end
  end

  // slower channels chained off the 1 ms enable
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !run) begin
      cnt200_reg <= 8'h00;
      cnt500_reg <= 9'h000;
      cnt5s_reg <= 13'h0000;
    end else if (tick_1ms) begin
      cnt200_reg <= tick_200ms ? 8'h00 : cnt200_reg + 8'h01;
      cnt500_reg <= tick_500ms ? 9'h000 : cnt500_reg + 9'h001;
      cnt5s_reg <= (tick_5s || !key_input_pin || state_reg != st_held) ?
        13'h0000 : cnt5s_reg + 13'h0001;
    end
  end
  // one-cycle pulses: counts sit still between 1 ms enables
  assign tick_200ms = tick_1ms && cnt200_reg == 8'(tick_200ms_ms - 1);
  assign tick_500ms = tick_1ms && cnt500_reg == 9'(tick_500ms_ms - 1);
  assign tick_5s = tick_1ms && cnt5s_reg == 13'(tick_5s_ms - 1);

  // rx only kept registered; module replies are not needed to ring
  always_ff @(posedge ref_clk) begin
    if (!rst_n) rx_sync_reg <= 1'b1;
    else rx_sync_reg <= radio_serial_rx_line;
  end

  assign tx_data = init_phase_reg ? init_bytes[byte_reg[0]] :
    msg_bytes[byte_reg[1:0]];
  assign tx_start = (state_reg == st_send) && !tx_busy;

  uart_tx #(.baud_div(baud_div)) u_tx (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .start(tx_start),
    .data(tx_data),
    .busy(tx_busy),
    .tx_line(tx_line)
  );

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_reg <= st_init;
      wait_reg <= 16'h0000;
      byte_reg <= 3'h0;
      init_phase_reg <= 1'b1;
      resend_done_reg <= 1'b0;
      blink_reg <= 5'h00;
      low_batt_reg <= 1'b0;
      adc_start <= 1'b0;
    end else begin
      adc_start <= 1'b0;
      unique case (state_reg)
        st_init: state_reg <= st_sleep;
        st_sleep: begin
          if (key_interrupt_input) begin
            state_reg <= st_debounce;
            wait_reg <= 16'h0000;
          end
        end
        st_debounce: begin
          if (!key_input_pin) state_reg <= st_sleep;
          else if (tick_1ms) begin
            if (wait_reg == 16'(debounce_ticks - 1))
              state_reg <= st_power;
            wait_reg <= wait_reg + 16'h0001;
          end
        end
        st_power: if (tick_1ms) state_reg <= st_reset;
        st_reset: begin
          if (tick_1ms) begin
            state_reg <= st_boot;
            wait_reg <= 16'h0000;
          end
        end
        st_boot: begin
          if (tick_200ms) begin
            state_reg <= st_send;
            byte_reg <= 3'h0;
            init_phase_reg <= 1'b1;
          end
        end
        st_send: begin
          if (tx_start) begin
            if (init_phase_reg && byte_reg == 3'(init_len - 1)) begin
              init_phase_reg <= 1'b0;
              byte_reg <= 3'h0;
            end else if (!init_phase_reg &&
                byte_reg == 3'(msg_len - 1)) begin
              state_reg <= st_held;
            end else begin
              byte_reg <= byte_reg + 3'h1;
            end
          end
        end
        st_held: begin
          if (!tx_busy && !key_input_pin) begin
            state_reg <= st_check;
            adc_start <= 1'b1;
          end else if (tick_5s && !resend_done_reg) begin
            resend_done_reg <= 1'b1;
            state_reg <= st_send;
            byte_reg <= 3'h0;
          end
        end
        st_check: begin
          if (adc_result.valid) begin
            low_batt_reg <= adc_result.value < adc_low_threshold;
            blink_reg <= 5'h00;
            resend_done_reg <= 1'b0;
            state_reg <= (adc_result.value < adc_low_threshold) ?
              st_blink : st_sleep;
          end
        end
        st_blink: begin
          if (tick_500ms) begin
            blink_reg <= blink_reg + 5'h01;
            if (blink_reg == 5'(blink_toggles - 1))
              state_reg <= st_sleep;
          end
        end
        default: state_reg <= st_sleep;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      led_drive_pin <= led_off_level;
      radio_power_switch_pin <= 1'b0;
      radio_reset_pin <= 1'b0;
      radio_serial_tx_line <= 1'b1;
    end else begin
      radio_serial_tx_line <= tx_line;
      radio_power_switch_pin <= state_reg inside {st_power, st_reset,
        st_boot, st_send, st_held};
      radio_reset_pin <= state_reg inside {st_boot, st_send, st_held};
      if (state_reg == st_blink)
        led_drive_pin <= blink_reg[0] ? led_on_level : led_off_level;
      else if (state_reg inside {st_power, st_reset, st_boot, st_send,
          st_held})
        led_drive_pin <= key_input_pin ? led_on_level : led_off_level;
      else
        led_drive_pin <= led_off_level;
    end
  end

  a_sleep_radio_off: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    state_reg == st_sleep |=> !radio_power_switch_pin)
    else $error("radio powered in sleep");
  a_wake_on_int: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    state_reg == st_sleep && key_interrupt_input |=> state_reg == st_debounce)
    else $error("interrupt did not wake");
  a_init_to_sleep: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    state_reg == st_init |=> state_reg == st_sleep)
    else $error("init did not sleep");
  a_led_active_low: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    state_reg == st_sleep ##1 state_reg == st_sleep |-> led_drive_pin)
    else $error("led lit in sleep");
  a_led_off_release: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    state_reg == st_held && !key_input_pin |=> led_drive_pin)
    else $error("led stayed on after release");
  // reset may only be let go once the supply is already on
  a_reset_after_pwr: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    $rose(radio_reset_pin) |-> radio_power_switch_pin)
    else $error("reset released without power");
  a_debounce_abort: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    state_reg == st_debounce && !key_input_pin |=> state_reg == st_sleep)
    else $error("bouncing key accepted");
  a_tick_period: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    tick_1ms && run |=> !tick_1ms)
    else $error("1 ms tick wider than one cycle");
  a_low_batt_blink: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    state_reg == st_check && adc_result.valid &&
    adc_result.value < adc_low_threshold |=> state_reg == st_blink)
    else $error("low battery not flagged");
  a_blink_low_batt: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    state_reg == st_blink |-> low_batt_reg)
    else $error("blink without low battery");
  c_wake: cover property (@(posedge ref_clk) state_reg == st_debounce);
  c_send: cover property (@(posedge ref_clk) state_reg == st_held);
  c_resend: cover property (@(posedge ref_clk) resend_done_reg);
  c_blink: cover property (@(posedge ref_clk) state_reg == st_blink);
  c_radio_idle: cover property (@(posedge ref_clk) radio_power_switch_pin &&
    rx_sync_reg);
endmodule

// ===== bench/radio_model.sv
`timescale 1ns/1ps
module radio_model #(
  parameter int unsigned baud_div = doorbell_pkg::baud_cycles
) (
  input wire logic ref_clk,
  input wire logic tx_line,
  input wire logic power_on,
  input wire logic reset_n,
  output logic rx_line,
  output logic [7:0] rx_byte,
  output logic byte_stb
);
  import doorbell_pkg::*;
  logic live;
  logic flip = 1'b0;
  assign live = power_on && reset_n;
  // unpowered module floats its line: show a moving level, not a held one
  always @(posedge ref_clk) flip <= ~flip;
  assign rx_line = live ? 1'b1 : flip;
  // frames seen while unpowered or in reset are lost, as on the real part
  initial begin
    rx_byte = 8'h00;
    byte_stb = 1'b0;
    forever begin
      @(posedge ref_clk);
      byte_stb <= 1'b0;
      if (live && tx_line === 1'b0) begin
        repeat (baud_div / 2) @(posedge ref_clk);
        for (int i = 0; i < 8; i++) begin
          repeat (baud_div) @(posedge ref_clk);
          rx_byte[i] <= tx_line;
        end
        repeat (baud_div) @(posedge ref_clk);
        if (tx_line === 1'b1) byte_stb <= 1'b1;
      end
    end
  end
endmodule

// ===== bench/tb.sv
`timescale 1ns/1ps
module tb;
  import doorbell_pkg::*;
  // scaled timebase and baud keep the whole run short
  localparam int unsigned tdiv = 2;
  localparam int unsigned bdiv = 8;
  localparam int limit = 50000;
  typedef struct {
    logic [9:0] level;
    int nbytes;
    int ntog;
  } row_type;
  // boundary level first: equal to threshold is not low
  row_type rows [2] = '{'{10'h3b6, 6, 0}, '{10'h3b5, 10, blink_toggles}};
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic key_int = 1'b0;
  logic key = 1'b0;
  adc_result_type adc = '0;
  logic [9:0] adc_val = 10'h000;
  logic rx_line, led, pwr, rrst, tx, adc_start, stb;
  logic [7:0] rx_byte;
  logic [7:0] got [$];
  logic led_q = 1'b1;
  int n_fail = 0;
  int checked = 0;
  int cycles = 0;
  int toggles = 0;
  int t0;

  always #2 ref_clk = ~ref_clk;

  doorbell_transmit_sequencer #(.tick_div(tdiv), .debounce_ticks(2),
    .baud_div(bdiv)) i_doorbell_transmit_sequencer (
    .ref_clk(ref_clk), .rst_n(rst_n), .key_interrupt_input(key_int),
    .key_input_pin(key), .adc_result(adc), .radio_serial_rx_line(rx_line),
    .led_drive_pin(led), .radio_power_switch_pin(pwr),
    .radio_reset_pin(rrst), .radio_serial_tx_line(tx),
    .adc_start(adc_start));

  radio_model #(.baud_div(bdiv)) i_radio_model (
    .ref_clk(ref_clk), .tx_line(tx), .power_on(pwr), .reset_n(rrst),
    .rx_line(rx_line), .rx_byte(rx_byte), .byte_stb(stb));

  task automatic chk(input string name, input logic [15:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic report_and_stop;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  function automatic logic [7:0] exp_byte(input int i);
    if (i < init_len) return init_bytes[i];
    return msg_bytes[(i - init_len) % msg_len];
  endfunction

  // timeout: a hang still lands on the verdict
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == limit) begin
      n_fail++;
      report_and_stop;
    end
  end

  always @(posedge ref_clk) begin
    if (stb) got.push_back(rx_byte);
    led_q <= led;
    if (led !== led_q) toggles <= toggles + 1;
    adc <= #1 '{valid: adc_start, value: adc_val};
  end

  initial begin
    step(5);
    chk("led_rst", led, led_off_level);
    chk("pwr_rst", pwr, 1'b0);
    chk("rrst_rst", rrst, 1'b0);
    chk("tx_rst", tx, 1'b1);
    chk("adc_rst", adc_start, 1'b0);
    rst_n = 1'b1;
    step(2);
    // level alone must not wake it
    key = 1'b1;
    step(10 * tdiv);
    chk("pwr_nowake", pwr, 1'b0);
    key = 1'b0;
    step(2);
    // bounce: key drops inside the debounce interval
    key_int = 1'b1;
    key = 1'b1;
    step(1);
    key_int = 1'b0;
    step(tdiv);
    key = 1'b0;
    step(10 * tdiv);
    chk("pwr_bounce", pwr, 1'b0);
    chk("led_bounce", led, led_off_level);
    foreach (rows[r]) begin
      got.delete();
      adc_val = rows[r].level;
      key_int = 1'b1;
      key = 1'b1;
      step(1);
      key_int = 1'b0;
      step(3 * tdiv + 3);
      chk("pwr_on", pwr, 1'b1);
      chk("led_on", led, led_on_level);
      step(2 * tdiv);
      chk("rrst_off", rrst, 1'b1);
      for (int k = 0; k < 30000 && got.size() < rows[r].nbytes; k++) step(1);
      chk("n_bytes", got.size(), rows[r].nbytes);
      foreach (got[i]) chk("byte", got[i], exp_byte(i));
      chk("led_held", led, led_on_level);
      step(bdiv);
      key = 1'b0;
      step(3);
      chk("led_rel", led, led_off_level);
      t0 = toggles;
      step(5000 * tdiv + 300 * tdiv);
      chk("toggles", toggles - t0, rows[r].ntog);
      chk("no_extra", got.size(), rows[r].nbytes);
      chk("pwr_sleep", pwr, 1'b0);
      chk("led_sleep", led, led_off_level);
      chk("tx_sleep", tx, 1'b1);
    end
    // reset while the radio is up must drop pwr, rrst, led and tx at once
    key_int = 1'b1;
    key = 1'b1;
    step(1);
    key_int = 1'b0;
    step(5 * tdiv + 4);
    chk("pwr_mid", pwr, 1'b1);
    rst_n = 1'b0;
    step(2);
    chk("pwr_mrst", pwr, 1'b0);
    chk("rrst_mrst", rrst, 1'b0);
    chk("led_mrst", led, led_off_level);
    chk("tx_mrst", tx, 1'b1);
    key = 1'b0;
    rst_n = 1'b1;
    step(2);
    chk("pwr_after", pwr, 1'b0);
    report_and_stop;
  end
endmodule
